/* design/npp_pkg.sv */
// Constants for the nibble port pin control block
package npp_pkg;
  localparam logic       BANK0          = 1'b0;
  localparam logic       BANK1          = 1'b1;
  localparam logic [6:0] ADDR_ANA_PORT  = 7'h72;
  localparam logic [6:0] ADDR_SHR_PORT  = 7'h73;
  localparam logic [6:0] ADDR_GRP_PORT  = 7'h70;
  localparam logic [6:0] ADDR_IN_PORT   = 7'h71;
  localparam logic [6:0] RF_ANA_SEL     = 7'h1B;
  localparam logic [6:0] RF_ANA_DIR     = 7'h1C;
  localparam logic [6:0] RF_SHR_DIR     = 7'h2B;
  localparam logic [6:0] RF_GRP_DIR     = 7'h2C;
  localparam logic [6:0] RF_FUNC_SEL    = 7'h0B;
  localparam int         BIT_SER_EN     = 0;
  localparam int         BIT_TMR_SEL    = 3;
  localparam int         BIT_GRP_DIR    = 2;
  localparam int         PIN_SCK        = 0;
  localparam int         PIN_SO         = 1;
  localparam int         PIN_SI         = 2;
  localparam int         PIN_TMR        = 3;
  localparam logic [3:0] NIB_ZERO       = 4'h0;
  localparam logic [1:0] SYNC_ZERO      = 2'h0;
endpackage : npp_pkg

/* design/npp_port.sv */
// Nibble port pin control: analog port tail, shared port, group port, input port
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// R1 - Analog select, input dir: analog input, read latch
// R2 - Analog select with output: latch still drives
// R3 - Shared port at bank0 73H, open-drain
// R4 - Shared pins per-bit direction from 2BH
// R5 - Reset clears shared direction and latch
// R6 - Direction change leaves shared latch unchanged
// R7 - Serial enable switches three low pins
// R8 - Timer select switches top pin
// R9 - Timer pin 1 at reset, toggles on match
// R10 - Special-function read sources per pin
// R11 - Serial shifting alters SO pin latch
// R12 - Group port bank1 70H, dir 2CH bit2
// R13 - Group dir 0 reads pins, 1 drives
// R14 - Reset clears group dir and latch
// R15 - Input port 71H: bit0 pin, writes ignored
// R16 - Analog select bits at 1BH
// R17 - Analog port at 72H, dir at 1CH
// R18 - Bank plus address selects; RF on write
module npp_port
  import npp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Data memory port access
  input  wire logic       dm_bank,
  input  wire logic [6:0] dm_addr,
  input  wire logic       dm_wr,
  input  wire logic [3:0] dm_wdata,
  output logic      [3:0] dm_rdata,
  output logic            dm_hit,
  // Register file access
  input  wire logic [6:0] rf_addr,
  input  wire logic       rf_wr,
  input  wire logic [3:0] rf_wdata,
  output logic      [3:0] rf_rdata,
  // Analog-capable port pins
  input  wire logic [3:0] ana_pin_in,
  output logic      [3:0] ana_pin_out,
  output logic      [3:0] ana_pin_oe,
  output logic      [3:0] analog_in_pin,
  // Shared port pins, open-drain
  input  wire logic [3:0] shr_pin_in,
  output logic      [3:0] shr_pin_out,
  output logic      [3:0] shr_pin_oe,
  // Group port pins, open-drain
  input  wire logic [3:0] grp_pin_in,
  output logic      [3:0] grp_pin_out,
  output logic      [3:0] grp_pin_oe,
  // Input-only pin
  input  wire logic       in_pin,
  // Serial engine
  input  wire logic       ser_int_clk,
  input  wire logic       ser_clk_out,
  input  wire logic       ser_so_bit,
  input  wire logic       ser_so_upd,
  output logic            ser_sck_in,
  output logic            ser_si_in,
  output logic            serial_pins_enable,
  // Timer 0
  input  wire logic       tmr0_reset,
  input  wire logic       tmr0_match
);
  typedef struct packed {
    logic [3:0] ana_latch;
    logic [3:0] analog_select_bit;
    logic [3:0] analog_port_dir_bit;
    logic [3:0] shr_latch;
    logic [3:0] shared_port_dir_bit;
    logic       ser_en;
    logic       timer_out_select;
    logic [3:0] grp_latch;
    logic       bank1_port_group_dir;
  } npp_state_t;

  npp_state_t st_r, st_nxt;
  logic [3:0] ana_sync;
  logic [3:0] shr_sync;
  logic [3:0] grp_sync;
  logic [3:0] in_sync;
  logic       timer0_toggle_out;

  // Pins are asynchronous to sys_clk
  npp_sync #(.W(4)) u_sync_ana (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (ana_pin_in),
    .dout    (ana_sync)
  );
  npp_sync #(.W(4)) u_sync_shr (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (shr_pin_in),
    .dout    (shr_sync)
  );
  npp_sync #(.W(4)) u_sync_grp (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (grp_pin_in),
    .dout    (grp_sync)
  );
  npp_sync #(.W(4)) u_sync_in (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     ({3'h0, in_pin}),
    .dout    (in_sync)
  );

  npp_timer_out u_tout (
    .sys_clk           (sys_clk),
    .rstn              (rstn),
    .tmr0_reset        (tmr0_reset),
    .tmr0_match        (tmr0_match),
    .timer0_toggle_out (timer0_toggle_out)
  );

  function automatic logic hit(input logic bank, input logic [6:0] addr,
                               input logic want_bank, input logic [6:0] want_addr);
    hit = (bank == want_bank) && (addr == want_addr); // R18
  endfunction

  // Per-bit read mux: latch where driven, pin where input
  function automatic logic [3:0] rd_mux(input logic [3:0] dir, input logic [3:0] latch,
                                        input logic [3:0] pins);
    rd_mux = (dir & latch) | (~dir & pins);
  endfunction

  logic sel_ana, sel_shr, sel_grp, sel_in;
  assign sel_ana = hit(dm_bank, dm_addr, BANK0, ADDR_ANA_PORT); // R17
  assign sel_shr = hit(dm_bank, dm_addr, BANK0, ADDR_SHR_PORT); // R3
  assign sel_grp = hit(dm_bank, dm_addr, BANK1, ADDR_GRP_PORT); // R12
  assign sel_in  = hit(dm_bank, dm_addr, BANK1, ADDR_IN_PORT);  // R15

  always_comb begin
    st_nxt = st_r;
    // Port latch writes; writes land regardless of direction
    if (dm_wr && sel_ana) begin
      st_nxt.ana_latch = dm_wdata;
    end
    if (dm_wr && sel_shr) begin
      st_nxt.shr_latch = dm_wdata; // R3
    end
    if (dm_wr && sel_grp) begin
      st_nxt.grp_latch = dm_wdata; // R12
    end
    // Shift engine overwrites SO latch; it wins over a same-cycle write
    if (st_r.ser_en && ser_so_upd) begin
      st_nxt.shr_latch[PIN_SO] = ser_so_bit; // R11
    end
    // Register file; direction writes never touch latches
    if (rf_wr) begin
      unique case (rf_addr)
        RF_ANA_SEL:  st_nxt.analog_select_bit   = rf_wdata; // R16
        RF_ANA_DIR:  st_nxt.analog_port_dir_bit = rf_wdata; // R17
        RF_SHR_DIR:  st_nxt.shared_port_dir_bit = rf_wdata; // R4 R6
        RF_FUNC_SEL: begin
          st_nxt.ser_en           = rf_wdata[BIT_SER_EN]; // R7
          st_nxt.timer_out_select = rf_wdata[BIT_TMR_SEL]; // R8
        end
        RF_GRP_DIR:  st_nxt.bank1_port_group_dir = rf_wdata[BIT_GRP_DIR]; // R12
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0; // R5 R14
    end else begin
      st_r <= st_nxt;
    end
  end

  // Register file readback
  always_comb begin
    rf_rdata = NIB_ZERO;
    unique case (rf_addr)
      RF_ANA_SEL:  rf_rdata = st_r.analog_select_bit;
      RF_ANA_DIR:  rf_rdata = st_r.analog_port_dir_bit;
      RF_SHR_DIR:  rf_rdata = st_r.shared_port_dir_bit;
      RF_FUNC_SEL: begin
        rf_rdata[BIT_SER_EN]  = st_r.ser_en;
        rf_rdata[BIT_TMR_SEL] = st_r.timer_out_select;
      end
      RF_GRP_DIR:  rf_rdata[BIT_GRP_DIR] = st_r.bank1_port_group_dir;
      default: ;
    endcase
  end

  assign serial_pins_enable = st_r.ser_en;

  // Analog port: latch drives whenever direction is output, even in analog use
  assign ana_pin_out   = st_r.ana_latch; // R2
  assign ana_pin_oe    = st_r.analog_port_dir_bit; // R2
  assign analog_in_pin = st_r.analog_select_bit; // R1

  // Shared port drive value per pin
  logic [3:0] shr_drv;
  logic [3:0] shr_en;
  always_comb begin
    shr_drv = st_r.shr_latch;
    shr_en  = st_r.shared_port_dir_bit; // R4
    if (st_r.ser_en) begin
      shr_drv[PIN_SCK] = ser_clk_out; // R7
      shr_en[PIN_SCK]  = ser_int_clk;
      shr_drv[PIN_SO]  = st_r.shr_latch[PIN_SO];
      shr_en[PIN_SO]   = 1'b1;
      shr_drv[PIN_SI]  = 1'b1;
      shr_en[PIN_SI]   = 1'b0;
    end
    if (st_r.timer_out_select) begin
      shr_drv[PIN_TMR] = timer0_toggle_out; // R8 R9
      shr_en[PIN_TMR]  = 1'b1;
    end
  end

  // Open-drain: only a driven 0 pulls the pin
  assign shr_pin_out = NIB_ZERO;
  assign shr_pin_oe  = shr_en & ~shr_drv; // R3
  assign grp_pin_out = NIB_ZERO;
  assign grp_pin_oe  = {4{st_r.bank1_port_group_dir}} & ~st_r.grp_latch; // R13

  assign ser_sck_in = shr_sync[PIN_SCK];
  assign ser_si_in  = shr_sync[PIN_SI];

  // Shared port read view
  logic [3:0] shr_rd;
  always_comb begin
    shr_rd = rd_mux(st_r.shared_port_dir_bit, st_r.shr_latch, shr_sync); // R4
    if (st_r.ser_en) begin
      shr_rd[PIN_SCK] = ser_int_clk ? st_r.shr_latch[PIN_SCK] : shr_sync[PIN_SCK]; // R10
      shr_rd[PIN_SO]  = st_r.shr_latch[PIN_SO]; // R10
      shr_rd[PIN_SI]  = shr_sync[PIN_SI]; // R10
    end
    if (st_r.timer_out_select) begin
      shr_rd[PIN_TMR] = st_r.shr_latch[PIN_TMR]; // R10
    end
  end

  // Data memory read
  always_comb begin
    dm_rdata = NIB_ZERO;
    dm_hit   = sel_ana | sel_shr | sel_grp | sel_in;
    if (sel_ana) begin
      dm_rdata = rd_mux(st_r.analog_port_dir_bit | st_r.analog_select_bit,
                        st_r.ana_latch, ana_sync); // R1
    end else if (sel_shr) begin
      dm_rdata = shr_rd;
    end else if (sel_grp) begin
      dm_rdata = rd_mux({4{st_r.bank1_port_group_dir}}, st_r.grp_latch, grp_sync); // R13
    end else if (sel_in) begin
      dm_rdata = {3'h0, in_sync[0]}; // R15
    end
  end
endmodule : npp_port
`default_nettype wire

/* design/npp_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module npp_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } npp_sync_t;
  npp_sync_t st_r, st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule : npp_sync
`default_nettype wire

/* design/npp_timer_out.sv */
// Timer 0 toggle output flop
`timescale 1ns/100ps
`default_nettype none
module npp_timer_out (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Timer 0 events
  input  wire logic tmr0_reset,
  input  wire logic tmr0_match,
  // Output
  output logic      timer0_toggle_out
);
  typedef struct packed {
    logic tog;
  } npp_tout_t;
  npp_tout_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (tmr0_reset) begin
      st_nxt.tog = 1'b1; // R9
    end else if (tmr0_match) begin
      st_nxt.tog = ~st_r.tog; // R9
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{tog: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timer0_toggle_out = st_r.tog;
endmodule : npp_timer_out
`default_nettype wire

/* testbench/npp_pin_model.sv */
// Pin-side model: pulled-up open-drain wires and an external driver
`timescale 1ns/100ps
`default_nettype none
module npp_pin_model (
  // Design pin drives
  input  wire logic [3:0] shr_oe,
  input  wire logic [3:0] grp_oe,
  input  wire logic [3:0] ana_out,
  input  wire logic [3:0] ana_oe,
  // External level, low pulls the wire
  input  wire logic [3:0] ext_lvl,
  // Wire levels
  output logic      [3:0] shr_pin,
  output logic      [3:0] grp_pin,
  output logic      [3:0] ana_pin
);
  // Pull-up holds a released open-drain wire high
  assign shr_pin = ~shr_oe & ext_lvl;
  assign grp_pin = ~grp_oe & ext_lvl;
  assign ana_pin = (ana_oe & ana_out) | (~ana_oe & ext_lvl);
endmodule // npp_pin_model

/* testbench/npp_port_sva.sv */
// Concurrent checks on the nibble port pin control ports
`timescale 1ns/100ps
`default_nettype none
module npp_port_sva
  import npp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Accesses
  input  wire logic       dm_bank,
  input  wire logic [6:0] dm_addr,
  input  wire logic       dm_wr,
  input  wire logic [3:0] dm_wdata,
  input  wire logic [3:0] dm_rdata,
  input  wire logic       dm_hit,
  input  wire logic [6:0] rf_addr,
  input  wire logic       rf_wr,
  input  wire logic [3:0] rf_wdata,
  // Pin drives
  input  wire logic [3:0] ana_pin_out,
  input  wire logic [3:0] ana_pin_oe,
  input  wire logic [3:0] analog_in_pin,
  input  wire logic [3:0] shr_pin_oe,
  input  wire logic [3:0] grp_pin_oe,
  input  wire logic       serial_pins_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_drive_off: assert property ($rose(rstn) |-> (shr_pin_oe | grp_pin_oe) == NIB_ZERO)
    else $error("pin pulled low after reset");
  a_ana_latch_wr: assert property (dm_wr && !dm_bank && dm_addr == ADDR_ANA_PORT |=>
    ana_pin_out == $past(dm_wdata)) else $error("analog port latch not written");
  a_ana_dir_wr: assert property (rf_wr && rf_addr == RF_ANA_DIR |=>
    ana_pin_oe == $past(rf_wdata)) else $error("analog port drive not set");
  a_ana_read_latch: assert property (!dm_bank && dm_addr == ADDR_ANA_PORT |->
    ((dm_rdata ^ ana_pin_out) & (analog_in_pin | ana_pin_oe)) == NIB_ZERO) else $error("bad read");
  a_grp_dir_off: assert property (rf_wr && rf_addr == RF_GRP_DIR && !rf_wdata[2] |=>
    grp_pin_oe == NIB_ZERO) else $error("group port still driving");
  a_shr_dir_off: assert property (rf_wr && rf_addr == RF_SHR_DIR && rf_wdata == NIB_ZERO
    && !serial_pins_enable |=> shr_pin_oe[2:0] == 3'h0) else $error("shared pin still driving");
  a_ser_enable_on: assert property (rf_wr && rf_addr == RF_FUNC_SEL && rf_wdata[0] |=>
    serial_pins_enable) else $error("serial enable not set");
  a_in_port_read: assert property (dm_bank && dm_addr == ADDR_IN_PORT |->
    dm_hit && dm_rdata[3:1] == 3'h0) else $error("input port read upper bits");
  c_grp_drive: cover property (grp_pin_oe != NIB_ZERO);
  c_ser_on: cover property (serial_pins_enable);
  c_ana_both: cover property ((analog_in_pin & ana_pin_oe) != NIB_ZERO);
endmodule // npp_port_sva
`default_nettype wire

/* testbench/test_nibble_port_pin_control.sv */
// Self-checking bench for the nibble port pin control block
`timescale 1ns/100ps
`default_nettype none
module test_nibble_port_pin_control
  import npp_pkg::*;
;
  logic       sys_clk, rstn = 1'b0, dm_bank = 1'b0, dm_wr = 1'b0, rf_wr = 1'b0, in_pin = 1'b0;
  logic       ser_so_upd = 1'b0, tmr0_reset = 1'b0, tmr0_match = 1'b0, dm_hit, ser_si_in, ser_en;
  logic       ser_int_clk = 1'b0, ser_clk_out = 1'b0, ser_sck_in;
  logic [3:0] rf_rdata;
  logic [6:0] dm_addr = 7'h00, rf_addr = 7'h00;
  logic [3:0] dm_wdata = 4'h0, rf_wdata = 4'h0, ext_lvl = 4'hF, dm_rdata, shr_pin, grp_pin;
  logic [3:0] ana_pin, ana_pin_out, ana_pin_oe, analog_in_pin, shr_pin_oe, grp_pin_oe;
  int         n_mismatch = 0, tests_run = 0;
  npp_port u_npp_port (.sys_clk, .rstn, .dm_bank, .dm_addr, .dm_wr, .dm_wdata, .dm_rdata,
    .dm_hit, .rf_addr, .rf_wr, .rf_wdata, .rf_rdata, .ana_pin_in(ana_pin), .ana_pin_out,
    .ana_pin_oe, .analog_in_pin, .shr_pin_in(shr_pin), .shr_pin_out(), .shr_pin_oe,
    .grp_pin_in(grp_pin), .grp_pin_out(), .grp_pin_oe, .in_pin, .ser_int_clk,
    .ser_clk_out, .ser_so_bit(1'b0), .ser_so_upd, .ser_sck_in, .ser_si_in,
    .serial_pins_enable(ser_en), .tmr0_reset, .tmr0_match);
  npp_pin_model u_npp_pin_model (.shr_oe(shr_pin_oe), .grp_oe(grp_pin_oe), .ana_out(ana_pin_out),
    .ana_oe(ana_pin_oe), .ext_lvl, .shr_pin, .grp_pin, .ana_pin);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic dw(input logic b, input logic [6:0] a, input logic [3:0] d);
    @(negedge sys_clk);
    {dm_bank, dm_addr, dm_wdata, dm_wr} = {b, a, d, 1'b1};
    @(negedge sys_clk);
    dm_wr = 1'b0;
  endtask
  task automatic rw(input logic [6:0] a, input logic [3:0] d);
    @(negedge sys_clk);
    {rf_addr, rf_wdata, rf_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    rf_wr = 1'b0;
  endtask
  // Three edges so pin changes clear the synchroniser
  task automatic rd(input logic b, input logic [6:0] a, input logic [3:0] exp);
    repeat (3) @(negedge sys_clk);
    {dm_bank, dm_addr} = {b, a};
    #1 chk(dm_rdata, exp);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic t_reset;
    chk(shr_pin_oe | grp_pin_oe, 4'h0);
    rd(BANK0, ADDR_SHR_PORT, 4'hF);
    rw(RF_SHR_DIR, 4'hF);
    #1 chk(rf_rdata, 4'hF);
    rd(BANK0, ADDR_SHR_PORT, 4'h0);
  endtask
  task automatic t_shared;
    dw(BANK0, ADDR_SHR_PORT, 4'hA);
    chk(shr_pin_oe, 4'h5);
    rw(RF_SHR_DIR, 4'h3);
    rd(BANK0, ADDR_SHR_PORT, 4'hE);
    rw(RF_SHR_DIR, 4'hF);
    rd(BANK0, ADDR_SHR_PORT, 4'hA);
  endtask
  task automatic t_group;
    dw(BANK1, ADDR_GRP_PORT, 4'h3);
    rw(RF_GRP_DIR, 4'h4);
    chk(grp_pin_oe, 4'hC);
    rd(BANK1, ADDR_GRP_PORT, 4'h3);
    rw(RF_GRP_DIR, 4'h0);
    ext_lvl = 4'h5;
    rd(BANK1, ADDR_GRP_PORT, 4'h5);
    ext_lvl = 4'hF;
  endtask
  task automatic t_input;
    in_pin = 1'b1;
    dw(BANK1, ADDR_IN_PORT, 4'h0);
    rd(BANK1, ADDR_IN_PORT, 4'h1);
    in_pin = 1'b0;
    rd(BANK1, ADDR_IN_PORT, 4'h0);
    rd(BANK1, ADDR_ANA_PORT, 4'h0);
  endtask
  task automatic t_analog;
    dw(BANK0, ADDR_ANA_PORT, 4'h6);
    rw(RF_ANA_DIR, 4'hF);
    rw(RF_ANA_SEL, 4'hF);
    chk(ana_pin_out & ana_pin_oe, 4'h6);
    chk(analog_in_pin, 4'hF);
    rw(RF_ANA_DIR, 4'h0);
    rd(BANK0, ADDR_ANA_PORT, 4'h6);
    rw(RF_ANA_SEL, 4'h0);
    rd(BANK0, ADDR_ANA_PORT, 4'hF);
  endtask
  task automatic t_timer;
    rw(RF_FUNC_SEL, 4'h8);
    #1 chk(rf_rdata, 4'h8);
    pulse(tmr0_reset);
    chk(shr_pin_oe, 4'h5);
    pulse(tmr0_match);
    chk(shr_pin_oe, 4'hD);
    pulse(tmr0_match);
    chk(shr_pin_oe, 4'h5);
  endtask
  task automatic t_serial;
    rw(RF_FUNC_SEL, 4'h1);
    chk({3'h0, ser_en}, 4'h1);
    ext_lvl = 4'hB;
    repeat (3) @(negedge sys_clk);
    chk({3'h0, ser_si_in}, 4'h0);
    rd(BANK0, ADDR_SHR_PORT, 4'hB);
    chk({3'h0, ser_sck_in}, 4'h1);
    // Internal clock: clock pin reads latch and is driven by the engine
    {ser_int_clk, ser_clk_out} = 2'h3;
    rd(BANK0, ADDR_SHR_PORT, 4'hA);
    chk(shr_pin_oe, 4'h0);
    ser_clk_out = 1'b0;
    #1 chk(shr_pin_oe, 4'h1);
    ser_int_clk = 1'b0;
    ext_lvl = 4'hF;
    pulse(ser_so_upd);
    rw(RF_FUNC_SEL, 4'h0);
    rd(BANK0, ADDR_SHR_PORT, 4'h8);
  endtask
  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    t_reset();
    t_shared();
    t_group();
    t_input();
    t_analog();
    t_timer();
    t_serial();
    wrap_up();
  end
  // Guard against a hang
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule // test_nibble_port_pin_control
bind npp_port npp_port_sva u_npp_port_sva (.sys_clk, .rstn, .dm_bank, .dm_addr, .dm_wr,
  .dm_wdata, .dm_rdata, .dm_hit, .rf_addr, .rf_wr, .rf_wdata, .ana_pin_out, .ana_pin_oe,
  .analog_in_pin, .shr_pin_oe, .grp_pin_oe, .serial_pins_enable);
`default_nettype wire
